// ==== inc/adc_gain_cfg_defines.vh ====
`ifndef ADC_GAIN_CFG_DEFINES_VH
`define ADC_GAIN_CFG_DEFINES_VH

// Byte addresses of the register slice
`define ADDR_ADC0_INTERNAL_REF_GAIN   32'h40030010
`define ADDR_ADC0_EXTERNAL_REF_GAIN   32'h40030014
`define ADDR_ADC0_SUPPLY_REF_GAIN     32'h40030018
`define ADDR_ADC0_SHARED_CONFIG_ALIAS 32'h4003001C
`define ADDR_ADC1_INTERNAL_REF_GAIN   32'h40030090
`define ADDR_ADC1_EXTERNAL_REF_GAIN   32'h40030094
`define ADDR_ADC1_SUPPLY_REF_GAIN     32'h40030098
`define ADDR_ADC1_SHARED_CONFIG_ALIAS 32'h4003009C

// Reset values
`define RST_SUPPLY_REF_GAIN   16'h5555
`define RST_SHARED_CONFIG     16'h0000
`define RST_FACTORY_PLACEHOLD 16'h0000

// Coefficient kinds within one converter
`define KIND_INTERNAL 2'h0
`define KIND_EXTERNAL 2'h1
`define KIND_SUPPLY   2'h2

// Reference selection codes of the converter control register
`define REF_INTERNAL 2'h0
`define REF_EXTERNAL 2'h1
`define REF_SECOND   2'h2
`define REF_SUPPLY   2'h3

// Field positions of the shared converter configuration register
`define CFG_SAMPLING_MODE_BIT 15
`define CFG_BIAS_BOOST_BIT    13
`define CFG_BIAS_PIN_MSB      11
`define CFG_BIAS_PIN_LSB      9
`define CFG_GROUND_SWITCH_PIN_EN_BIT     8
`define CFG_GROUND_SWITCH_PIN_RES_BIT    7
`define CFG_EXT_BUF_MSB       2
`define CFG_EXT_BUF_LSB       0
`define CFG_WRITABLE_MASK     16'hAF87

// Bias pin select codes
`define BIAS_OFF_LOW  3'h0
`define BIAS_INPUT_7  3'h4
`define BIAS_INPUT_11 3'h6
`define BIAS_OFF_HIGH 3'h7

// External buffer mode codes
`define EXTBUF_OFF      3'h0
`define EXTBUF_POS_NEG  3'h1
`define EXTBUF_POS_REF2 3'h2
`define EXTBUF_POS_ONLY 3'h3
`define EXTBUF_REF2     3'h4

`endif

// ==== hdl/adc_gain_cal_and_config_regs.v ====
`timescale 1ns/10ps
`default_nettype none
`include "adc_gain_cfg_defines.vh"
module adc_gain_cal_and_config_regs (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire [15:0] factory_int_gain0,
  input  wire [15:0] factory_ext_gain0,
  input  wire [15:0] factory_int_gain1,
  input  wire [15:0] factory_ext_gain1,
  input  wire [1:0]  ref_sel0,
  input  wire [1:0]  ref_sel1,
  input  wire        cal_done0,
  input  wire        cal_done1,
  input  wire [15:0] cal_gain0,
  input  wire [15:0] cal_gain1,
  output wire [15:0] active_gain0,
  output wire [15:0] active_gain1,
  output wire        sampling_simultaneous,
  output wire        adc0_use_second_filter,
  output wire        bias_drive_boost,
  output wire        bias_gen_enable,
  output wire        bias_to_analog_input_7,
  output wire        bias_to_analog_input_11,
  output wire        ground_switch_connect,
  output wire        ground_switch_series_res,
  output wire        ext_buf_pos_en,
  output wire        ext_buf_neg_en,
  output wire        ext_buf_ref2_en
);

  // Coefficient store, index = converter * 3 + kind
  reg  [15:0] gain_q [0:5];
  reg  [15:0] cfg_q;
  reg         load_q;
  reg  [31:0] prdata_q;
  reg  [15:0] act0_q;
  reg  [15:0] act1_q;
  reg         simultaneous_q;
  reg         boost_q;
  reg         bias_en_q;
  reg         route7_q;
  reg         route11_q;
  reg         gsw_q;
  reg         gres_q;
  reg         bpos_q;
  reg         bneg_q;
  reg         bref2_q;

  reg         hit;
  reg         is_cfg;
  reg  [2:0]  gidx;
  reg  [15:0] rd_val;
  reg  [2:0]  cal_idx0;
  reg  [2:0]  cal_idx1;
  wire        wr_acc;
  wire        gain_wr;
  wire        cfg_wr;
  integer     i;

  // Zero-wait slave; unmapped access answers with an error
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign prdata  = prdata_q;
  assign wr_acc  = psel & penable & pwrite & hit;

  // Write strobes split by target; both aliases share one strobe
  assign gain_wr = wr_acc & ~is_cfg;
  assign cfg_wr  = wr_acc & is_cfg;

  // Address decode and read mux
  always @* begin
    hit    = 1'b1;
    is_cfg = 1'b0;
    gidx   = 3'h0;
    case (paddr)
      `ADDR_ADC0_INTERNAL_REF_GAIN:   gidx = 3'h0;
      `ADDR_ADC0_EXTERNAL_REF_GAIN:   gidx = 3'h1;
      `ADDR_ADC0_SUPPLY_REF_GAIN:     gidx = 3'h2;
      `ADDR_ADC1_INTERNAL_REF_GAIN:   gidx = 3'h3;
      `ADDR_ADC1_EXTERNAL_REF_GAIN:   gidx = 3'h4;
      `ADDR_ADC1_SUPPLY_REF_GAIN:     gidx = 3'h5;
      `ADDR_ADC0_SHARED_CONFIG_ALIAS: is_cfg = 1'b1;
      `ADDR_ADC1_SHARED_CONFIG_ALIAS: is_cfg = 1'b1;
      default:                        hit = 1'b0;
    endcase
    if (!hit) begin
      rd_val = 16'h0000;
    end else if (is_cfg) begin
      rd_val = cfg_q;
    end else begin
      rd_val = gain_q[gidx];
    end
  end

  // Calibration target follows the current reference selection
  always @* begin
    case (ref_sel0)
      `REF_INTERNAL: cal_idx0 = 3'h0;
      `REF_SUPPLY:   cal_idx0 = 3'h2;
      default:       cal_idx0 = 3'h1;
    endcase
    case (ref_sel1)
      `REF_INTERNAL: cal_idx1 = 3'h3;
      `REF_SUPPLY:   cal_idx1 = 3'h5;
      default:       cal_idx1 = 3'h4;
    endcase
  end

  // Read data captured in the setup cycle, shown in the access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata_q <= {16'h0000, rd_val};
    end
  end

  // Gain coefficient storage; calibration wins over a bus write
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < 6; i = i + 1) begin
        gain_q[i] <= `RST_FACTORY_PLACEHOLD;
      end
      gain_q[2] <= `RST_SUPPLY_REF_GAIN;
      gain_q[5] <= `RST_SUPPLY_REF_GAIN;
      load_q    <= 1'b1;
    end else begin
      load_q <= 1'b0;
      if (load_q) begin
        gain_q[0] <= factory_int_gain0;
        gain_q[1] <= factory_ext_gain0;
        gain_q[3] <= factory_int_gain1;
        gain_q[4] <= factory_ext_gain1;
      end else begin
        if (gain_wr) begin
          gain_q[gidx] <= pwdata[15:0];
        end
        if (cal_done0) begin
          gain_q[cal_idx0] <= cal_gain0;
        end
        if (cal_done1) begin
          gain_q[cal_idx1] <= cal_gain1;
        end
      end
    end
  end

  // Shared configuration register, one store behind two aliases
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= `RST_SHARED_CONFIG;
    end else if (cfg_wr) begin
      cfg_q <= pwdata[15:0] & `CFG_WRITABLE_MASK;
    end
  end

  // Applied coefficient of converter 0 follows its reference selection
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act0_q <= 16'h0000;
    end else begin
      case (ref_sel0)
        `REF_INTERNAL: act0_q <= gain_q[0];
        `REF_SUPPLY:   act0_q <= gain_q[2];
        default:       act0_q <= gain_q[1];
      endcase
    end
  end

  // Applied coefficient of converter 1; second reference uses external
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act1_q <= 16'h0000;
    end else begin
      case (ref_sel1)
        `REF_INTERNAL: act1_q <= gain_q[3];
        `REF_SUPPLY:   act1_q <= gain_q[5];
        default:       act1_q <= gain_q[4];
      endcase
    end
  end

  // Single-bit controls, one cycle behind the shared register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      simultaneous_q <= 1'b0;
      boost_q        <= 1'b0;
      gsw_q          <= 1'b0;
      gres_q         <= 1'b0;
    end else begin
      simultaneous_q <= ~cfg_q[`CFG_SAMPLING_MODE_BIT];
      boost_q        <= cfg_q[`CFG_BIAS_BOOST_BIT];
      gsw_q          <= cfg_q[`CFG_GROUND_SWITCH_PIN_EN_BIT];
      gres_q         <= cfg_q[`CFG_GROUND_SWITCH_PIN_RES_BIT];
    end
  end

  // Bias routing; reserved codes leave the generator off
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bias_en_q <= 1'b0;
      route7_q  <= 1'b0;
      route11_q <= 1'b0;
    end else begin
      case (cfg_q[`CFG_BIAS_PIN_MSB:`CFG_BIAS_PIN_LSB])
        `BIAS_INPUT_7: begin
          bias_en_q <= 1'b1;
          route7_q  <= 1'b1;
          route11_q <= 1'b0;
        end
        `BIAS_INPUT_11: begin
          bias_en_q <= 1'b1;
          route7_q  <= 1'b0;
          route11_q <= 1'b1;
        end
        default: begin
          bias_en_q <= 1'b0;
          route7_q  <= 1'b0;
          route11_q <= 1'b0;
        end
      endcase
    end
  end

  // Reference buffer enables; reserved codes power every buffer down
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bpos_q  <= 1'b0;
      bneg_q  <= 1'b0;
      bref2_q <= 1'b0;
    end else begin
      case (cfg_q[`CFG_EXT_BUF_MSB:`CFG_EXT_BUF_LSB])
        `EXTBUF_POS_NEG: begin
          bpos_q  <= 1'b1;
          bneg_q  <= 1'b1;
          bref2_q <= 1'b0;
        end
        `EXTBUF_POS_REF2: begin
          bpos_q  <= 1'b1;
          bneg_q  <= 1'b0;
          bref2_q <= 1'b1;
        end
        `EXTBUF_POS_ONLY: begin
          bpos_q  <= 1'b1;
          bneg_q  <= 1'b0;
          bref2_q <= 1'b0;
        end
        `EXTBUF_REF2: begin
          bpos_q  <= 1'b0;
          bneg_q  <= 1'b0;
          bref2_q <= 1'b1;
        end
        default: begin
          bpos_q  <= 1'b0;
          bneg_q  <= 1'b0;
          bref2_q <= 1'b0;
        end
      endcase
    end
  end

  // Registered outputs
  assign active_gain0             = act0_q;
  assign active_gain1             = act1_q;
  assign sampling_simultaneous    = simultaneous_q;
  assign adc0_use_second_filter   = simultaneous_q;
  assign bias_drive_boost         = boost_q;
  assign bias_gen_enable          = bias_en_q;
  assign bias_to_analog_input_7   = route7_q;
  assign bias_to_analog_input_11  = route11_q;
  assign ground_switch_connect    = gsw_q;
  assign ground_switch_series_res = gres_q;
  assign ext_buf_pos_en           = bpos_q;
  assign ext_buf_neg_en           = bneg_q;
  assign ext_buf_ref2_en          = bref2_q;

endmodule
`default_nettype wire

// ==== sim/adc_regs_properties.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "adc_gain_cfg_defines.vh"
module adc_regs_properties (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        cal_done0,
  input wire logic [1:0]  ref_sel0,
  input wire logic [15:0] cal_gain0,
  input wire logic [15:0] active_gain0,
  input wire logic        sampling_simultaneous,
  input wire logic        adc0_use_second_filter,
  input wire logic        bias_drive_boost,
  input wire logic        bias_gen_enable,
  input wire logic        bias_to_analog_input_7,
  input wire logic        ground_switch_connect,
  input wire logic        ground_switch_series_res,
  input wire logic        ext_buf_pos_en,
  input wire logic        ext_buf_neg_en,
  input wire logic        ext_buf_ref2_en
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Completed write through either alias of the shared configuration
  wire cfg_wr = psel & penable & pwrite &
    (paddr == `ADDR_ADC0_SHARED_CONFIG_ALIAS |
     paddr == `ADDR_ADC1_SHARED_CONFIG_ALIAS);
  // Decoded outputs follow a configuration write two edges later
  a_sampling_mode: assert property (cfg_wr |-> ##2
    sampling_simultaneous == !$past(pwdata[15], 2) &&
    adc0_use_second_filter == sampling_simultaneous)
    else $error("sampling mode output wrong");
  a_bias_boost: assert property (cfg_wr |=> ##1
    bias_drive_boost == $past(pwdata[13], 2))
    else $error("bias boost output wrong");
  a_ground_switch: assert property (cfg_wr ##2 1'b1 |->
    {ground_switch_connect, ground_switch_series_res}
      == $past(pwdata[8:7], 2))
    else $error("ground switch outputs wrong");
  a_bias_input_7: assert property (cfg_wr &&
    pwdata[11:9] == `BIAS_INPUT_7 |-> ##2
    bias_gen_enable && bias_to_analog_input_7)
    else $error("bias not routed to input 7");
  a_bias_off: assert property (cfg_wr &&
    pwdata[11:9] == `BIAS_OFF_HIGH |-> ##2 !bias_gen_enable)
    else $error("bias generator not off");
  a_buffers_off: assert property (cfg_wr &&
    pwdata[2:0] == `EXTBUF_OFF |-> ##2
    !(ext_buf_pos_en | ext_buf_neg_en | ext_buf_ref2_en))
    else $error("reference buffers not off");
  a_cal_supply: assert property (cal_done0 &&
    ref_sel0 == `REF_SUPPLY ##1 ref_sel0 == `REF_SUPPLY |=>
    active_gain0 == $past(cal_gain0, 2))
    else $error("calibrated gain not applied");
  a_read_width: assert property (prdata[31:16] == 16'h0000)
    else $error("read data above bit 15 not zero");
  // Main scenarios reached
  c_cfg_write: cover property (cfg_wr);
  c_cal: cover property (cal_done0);
  c_err: cover property (pslverr);
endmodule
bind adc_gain_cal_and_config_regs adc_regs_properties i_props (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pslverr, .cal_done0, .ref_sel0, .cal_gain0, .active_gain0,
  .sampling_simultaneous, .adc0_use_second_filter, .bias_drive_boost,
  .bias_gen_enable, .bias_to_analog_input_7, .ground_switch_connect,
  .ground_switch_series_res, .ext_buf_pos_en, .ext_buf_neg_en,
  .ext_buf_ref2_en);
`default_nettype wire

// ==== sim/adc_gain_cal_and_config_regs_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "adc_gain_cfg_defines.vh"
module adc_gain_cal_and_config_regs_tb;
  logic        pclk, presetn, psel, penable, pwrite, cal_done0, cal_done1;
  logic [31:0] paddr, pwdata, prdata, rd, d;
  logic        pready, pslverr, perr;
  logic [15:0] factory_int_gain0, factory_ext_gain0, factory_int_gain1;
  logic [15:0] factory_ext_gain1, cal_gain0, cal_gain1, m [8];
  logic [15:0] active_gain0, active_gain1;
  logic [1:0]  ref_sel0, ref_sel1;
  logic        sampling_simultaneous, adc0_use_second_filter;
  logic        bias_drive_boost, bias_gen_enable;
  logic        bias_to_analog_input_7, bias_to_analog_input_11;
  logic        ground_switch_connect, ground_switch_series_res;
  logic        ext_buf_pos_en, ext_buf_neg_en, ext_buf_ref2_en;
  logic [10:0] ev;
  int          miscompares, checks, k;
  logic [31:0] adr [8] = '{`ADDR_ADC0_INTERNAL_REF_GAIN,
    `ADDR_ADC0_EXTERNAL_REF_GAIN, `ADDR_ADC0_SUPPLY_REF_GAIN,
    `ADDR_ADC0_SHARED_CONFIG_ALIAS, `ADDR_ADC1_INTERNAL_REF_GAIN,
    `ADDR_ADC1_EXTERNAL_REF_GAIN, `ADDR_ADC1_SUPPLY_REF_GAIN,
    `ADDR_ADC1_SHARED_CONFIG_ALIAS};

  adc_gain_cal_and_config_regs i_adc_gain_cal_and_config_regs (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .factory_int_gain0, .factory_ext_gain0,
    .factory_int_gain1, .factory_ext_gain1, .ref_sel0, .ref_sel1,
    .cal_done0, .cal_done1, .cal_gain0, .cal_gain1, .active_gain0,
    .active_gain1, .sampling_simultaneous, .adc0_use_second_filter,
    .bias_drive_boost, .bias_gen_enable, .bias_to_analog_input_7,
    .bias_to_analog_input_11,
    .ground_switch_connect, .ground_switch_series_res, .ext_buf_pos_en,
    .ext_buf_neg_en, .ext_buf_ref2_en);

  // Free running clock
  always #2.5 pclk = ~pclk;

  // One APB transfer: setup, then access until pready
  task automatic apb(input logic w, input logic [31:0] a,
                     input logic [31:0] dt);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dt;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Cut a hang short
  initial begin
    #20000;
    miscompares++;
    $display("FAIL watchdog expected end seen hang");
    print_verdict;
  end

  // Test sequence
  initial begin
    {pclk, presetn, psel, penable, pwrite, cal_done0, cal_done1} = '0;
    {paddr, pwdata, ref_sel0, ref_sel1, cal_gain0, cal_gain1} = '0;
    m = '{16'h1A2B, 16'h3C4D, `RST_SUPPLY_REF_GAIN, `RST_SHARED_CONFIG,
      16'h5E6F, 16'h7081, `RST_SUPPLY_REF_GAIN, `RST_SHARED_CONFIG};
    {factory_int_gain0, factory_ext_gain0} = {m[0], m[1]};
    {factory_int_gain1, factory_ext_gain1} = {m[4], m[5]};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    for (k = 0; k < 8; k++) begin
      apb(1'b0, adr[k], '0);
      chk("reset value", m[k], rd);
      chk("ready", 32'h1, pready);
    end
    $display("test reset values done");
    for (k = 0; k < 8; k++) begin
      d = 32'hFFFF_0000 | (32'h1357 + 32'h1111 * k);
      apb(1'b1, adr[k], d);
      if (k % 4 == 3) {m[3], m[7]} = {2{d[15:0] & `CFG_WRITABLE_MASK}};
      else m[k] = d[15:0];
    end
    for (k = 0; k < 8; k++) begin
      apb(1'b0, adr[k], '0);
      chk("readback", m[k], rd);
      chk("mapped error", 32'h0, perr);
    end
    $display("test write readback done");
    for (k = 0; k < 4; k++) begin
      ref_sel0 <= k[1:0];
      ref_sel1 <= k[1:0];
      repeat (3) @(posedge pclk);
      chk("gain select 0", m[k == 3 ? 2 : k != 0], active_gain0);
      chk("gain select 1", m[k == 3 ? 6 : 4 + (k != 0)], active_gain1);
    end
    $display("test gain select done");
    for (k = 0; k < 8; k++) begin
      d = {k[0], 1'b0, k[1], 1'b0, k[2:0], k[2], ~k[0], 4'h0, k[2:0]};
      apb(1'b1, k[0] ? adr[7] : adr[3], d);
      repeat (2) @(posedge pclk);
      ev = {~k[0], ~k[0], k[1], k == 4 || k == 6, k == 4, k == 6, k[2],
        ~k[0], k inside {[1:3]}, k == 1, k == 2 || k == 4};
      chk("config decode", ev, {sampling_simultaneous, adc0_use_second_filter,
        bias_drive_boost, bias_gen_enable, bias_to_analog_input_7,
        bias_to_analog_input_11, ground_switch_connect,
        ground_switch_series_res, ext_buf_pos_en,
        ext_buf_neg_en, ext_buf_ref2_en});
    end
    $display("test config decode done");
    ref_sel0 <= `REF_SUPPLY;
    ref_sel1 <= `REF_SECOND;
    {cal_gain0, cal_gain1} <= {16'hC0DE, 16'hBEEF};
    {cal_done0, cal_done1} <= 2'b11;
    @(posedge pclk);
    {cal_done0, cal_done1} <= 2'b00;
    repeat (2) @(posedge pclk);
    chk("cal applied 0", 16'hC0DE, active_gain0);
    chk("cal applied 1", 16'hBEEF, active_gain1);
    apb(1'b0, `ADDR_ADC1_EXTERNAL_REF_GAIN, '0);
    chk("cal stored", 16'hBEEF, rd);
    $display("test calibration done");
    apb(1'b1, 32'h4003_0024, 32'h0000_FFFF);
    chk("unmapped error", 32'h1, perr);
    apb(1'b0, 32'h4003_0024, '0);
    chk("unmapped read", 32'h0, rd);
    $display("test unmapped done");
    print_verdict;
  end
endmodule
`default_nettype wire
